// >>> src/pgr_pkg.sv
// Shared constants and types for the PCI grant/request pin block.
// Assumes a single 20 MHz core clock; no software-visible registers.
package pgr_pkg;

	localparam int unsigned N_EXT        = 4;
	localparam int unsigned GNT_OWN_IDX  = 0;
	localparam int unsigned N_MASTERS    = N_EXT + 1;
	localparam int unsigned DEV_IDX      = N_EXT;
	localparam int unsigned LAST_IDX     = N_EXT - 1;
	localparam logic [3:0]  GNT_IDLE     = 4'hF;
	localparam logic [4:0]  GRANT_RESET  = 5'h00;
	localparam logic [4:0]  LAST_RESET   = 5'h10;
	localparam logic        STRAP_RESET  = 1'b1;
	localparam real         CLK_PERIOD_NS = 50.0;

	typedef enum logic [1:0] {
		PGR_IDLE,
		PGR_OWNED,
		PGR_TURN
	} pgr_arb_state_t;

	// Device pins of the arbitration group
	typedef struct packed {
		logic [3:0] gnt_n_o;
		logic [3:0] gnt_oe_n;
		logic       req0_n_o;
		logic       req0_oe_n;
		logic       irdy_n_o;
		logic       irdy_oe_n;
		logic       lock_n_o;
		logic       lock_oe_n;
	} pgr_pins_out_t;

	typedef struct packed {
		logic [3:0] req_n_i;
		logic       gnt0_n_i;
		logic       frame_n_i;
		logic       irdy_n_i;
		logic       lock_n_i;
	} pgr_pins_in_t;

endpackage

// >>> src/pgr_rr_arb.sv
// Round-robin priority picker over a request vector.
// Assumes the caller decides when a new pick may take effect.
`timescale 1ns/1ps
`default_nettype none
module pgr_rr_arb #(
	parameter int unsigned N = 5
) (
	input  wire logic [N-1:0] req,
	input  wire logic [N-1:0] last,
	output logic      [N-1:0] pick
);
	logic [2*N-1:0] req2;
	logic [2*N-1:0] mask2;
	logic [2*N-1:0] hit2;

	assign req2 = {req, req};

	// --------------------------------------------------------------
	// Mask of positions after the last winner
	// --------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2 * N; gi++) begin : g_mask
			if (gi == 0) begin : g_first
				assign mask2[gi] = 1'b0;
			end else begin : g_rest
				assign mask2[gi] = mask2[gi-1] | last[(gi-1) % N];
			end
		end
	endgenerate

	// First request above the previous winner
	assign hit2 = (req2 & mask2) & ~((req2 & mask2) - 1'b1);

	always_comb begin
		pick = hit2[N-1:0] | hit2[2*N-1:N];
		if (req == '0) begin
			pick = '0;
		end
	end
endmodule
`default_nettype wire

// >>> src/pgr_top.sv
// PCI-side grant/request pin logic with strap-selected arbiter mode.
// Assumes PCI pins are synchronous to core_clk; pad wires built outside.
`timescale 1ns/1ps
`default_nettype none
module pgr_top
	import pgr_pkg::*;
#(
	parameter int unsigned N_EXT_P = pgr_pkg::N_EXT
) (
	input  wire logic                   core_clk,
	input  wire logic                   nrst,
	input  wire logic                   arbiter_enable_strap,
	input  wire logic                   test_spare2,
	input  wire pgr_pkg::pgr_pins_in_t  pins_i,
	output var  pgr_pkg::pgr_pins_out_t pins_o,
	input  wire logic                   own_req,
	input  wire logic                   own_active,
	input  wire logic                   own_ready,
	input  wire logic                   own_lock,
	output logic                        own_gnt,
	output logic                        int_arb_mode,
	output logic                        lock_busy,
	output logic [3:0]                  ext_gnt_state
);
	import pgr_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_m_q;
	logic rst_n_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// ------------------------------------------------------------
	// Strap capture after reset release
	// ------------------------------------------------------------
	logic strap_q;
	logic strap_done_q;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			strap_q      <= STRAP_RESET;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_q      <= arbiter_enable_strap;
			strap_done_q <= 1'b1;
		end
	end
	assign int_arb_mode = strap_q;

	// ------------------------------------------------------------
	// Request vector and bus idle
	// ------------------------------------------------------------
	logic [N_MASTERS-1:0] req_vec;
	logic                 bus_idle;
	logic [N_MASTERS-1:0] pick;
	logic [N_MASTERS-1:0] grant_q;
	logic [N_MASTERS-1:0] last_q;
	pgr_arb_state_t       state_q;

	// four external request lines plus own_req for the device make up the five requesters
	assign req_vec  = {own_req, ~pins_i.req_n_i};
	assign bus_idle = pins_i.frame_n_i & pins_i.irdy_n_i;

	pgr_rr_arb #(
		.N    (N_MASTERS)
	) u_rr (
		.req  (req_vec),
		.last (last_q),
		.pick (pick)
	);

	// ------------------------------------------------------------
	// Internal arbiter
	// ------------------------------------------------------------
	logic [N_MASTERS-1:0] park;
	always_comb begin
		park = '0;
		if (test_spare2) begin
			park[LAST_IDX] = 1'b1;
		end else begin
			park[DEV_IDX] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			grant_q <= GRANT_RESET;
			last_q  <= LAST_RESET;
			state_q <= PGR_IDLE;
		end else if (!strap_q || !strap_done_q) begin
			grant_q <= GRANT_RESET;
			state_q <= PGR_IDLE;
		end else begin
			case (state_q)
				PGR_IDLE: begin
					if (bus_idle) begin
						if (pick != '0) begin
							grant_q <= pick;
							last_q  <= pick;
							state_q <= PGR_OWNED;
						end else begin
							grant_q <= park;
						end
					end
				end
				PGR_OWNED: begin
					// Owner dropped request: retract grant once
					if ((grant_q & req_vec) == '0) begin
						grant_q <= GRANT_RESET;
						state_q <= PGR_TURN;
					end
				end
				PGR_TURN: begin
					// One dead cycle avoids two masters on the bus
					state_q <= PGR_IDLE;
				end
				default: begin
					grant_q <= GRANT_RESET;
					state_q <= PGR_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Device ownership
	// ------------------------------------------------------------
	logic own_gnt_q;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			own_gnt_q <= 1'b0;
		end else if (strap_q) begin
			own_gnt_q <= grant_q[DEV_IDX];
		end else begin
			own_gnt_q <= ~pins_i.gnt0_n_i;
		end
	end
	assign own_gnt = own_gnt_q;

	// ------------------------------------------------------------
	// Grant and request pins
	// ------------------------------------------------------------
	logic [3:0] gnt_n_q;
	logic [3:0] gnt_oe_n_q;
	logic       req0_n_q;
	logic       req0_oe_n_q;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			gnt_n_q     <= GNT_IDLE;
			gnt_oe_n_q  <= GNT_IDLE;
			req0_n_q    <= 1'b1;
			req0_oe_n_q <= 1'b1;
		end else if (!strap_done_q) begin
			// Keep every pin released until the strap is known
			gnt_n_q     <= GNT_IDLE;
			gnt_oe_n_q  <= GNT_IDLE;
			req0_n_q    <= 1'b1;
			req0_oe_n_q <= 1'b1;
		end else if (strap_q) begin
			gnt_n_q     <= ~grant_q[N_EXT-1:0];
			gnt_oe_n_q  <= 4'h0;
			req0_n_q    <= 1'b1;
			req0_oe_n_q <= 1'b1;
		end else begin
			gnt_n_q     <= GNT_IDLE;
			gnt_oe_n_q  <= 4'h1;
			req0_n_q    <= ~own_req;
			req0_oe_n_q <= 1'b0;
		end
	end
	assign ext_gnt_state = ~gnt_n_q;

	// ------------------------------------------------------------
	// Initiator ready and lock
	// ------------------------------------------------------------
	logic irdy_n_q;
	logic irdy_oe_n_q;
	logic lock_hold_q;
	logic lock_busy_q;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irdy_n_q    <= 1'b1;
			irdy_oe_n_q <= 1'b1;
		end else begin
			irdy_n_q    <= ~(own_ready & own_active);
			irdy_oe_n_q <= ~(own_gnt_q & own_active);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lock_hold_q <= 1'b0;
		end else if (!own_lock) begin
			lock_hold_q <= 1'b0;
		end else if (own_gnt_q && own_active) begin
			// Held across later transactions until released
			lock_hold_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lock_busy_q <= 1'b0;
		end else begin
			lock_busy_q <= ~pins_i.lock_n_i & ~lock_hold_q;
		end
	end
	assign lock_busy = lock_busy_q;

	always_comb begin
		pins_o           = '0;
		pins_o.gnt_n_o   = gnt_n_q;
		pins_o.gnt_oe_n  = gnt_oe_n_q;
		pins_o.req0_n_o  = req0_n_q;
		pins_o.req0_oe_n = req0_oe_n_q;
		pins_o.irdy_n_o  = irdy_n_q;
		pins_o.irdy_oe_n = irdy_oe_n_q;
		pins_o.lock_n_o  = 1'b0;
		pins_o.lock_oe_n = ~lock_hold_q;
	end
endmodule
`default_nettype wire

// >>> verif/pgr_sva.sv
// Checker for pgr_top port behaviour.
// Bound from tb_top; sees only the top ports.
`timescale 1ns/1ps
`default_nettype none
module pgr_sva
	import pgr_pkg::*;
(
	input wire logic                  core_clk,
	input wire logic                  nrst,
	input wire logic                  arbiter_enable_strap,
	input wire logic                  test_spare2,
	input wire pgr_pkg::pgr_pins_in_t  pins_i,
	input wire pgr_pkg::pgr_pins_out_t pins_o,
	input wire logic                  own_req,
	input wire logic                  own_active,
	input wire logic                  own_ready,
	input wire logic                  own_lock,
	input wire logic                  own_gnt,
	input wire logic                  int_arb_mode,
	input wire logic [3:0]            ext_gnt_state
);
	logic [2:0] rc_q;
	logic       ok;
	// Settling time after reset release
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			rc_q <= 3'h0;
		else if (rc_q != 3'h7)
			rc_q <= rc_q + 3'h1;
	end
	assign ok = rc_q == 3'h7;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_int_oe;
		ok && int_arb_mode |-> pins_o.gnt_oe_n == 4'h0;
	endproperty
	a_int_oe: assert property (p_int_oe) else $error("grant not driven");
	property p_int_gnt;
		ok && int_arb_mode |-> $onehot0(~pins_o.gnt_n_o)
			&& ext_gnt_state == ~pins_o.gnt_n_o;
	endproperty
	a_int_gnt: assert property (p_int_gnt) else $error("bad grant");
	property p_ext_dir;
		ok && !int_arb_mode |-> pins_o.gnt_oe_n == 4'h1;
	endproperty
	a_ext_dir: assert property (p_ext_dir) else $error("grant dir");
	property p_ext_idle;
		ok && !int_arb_mode |-> pins_o.gnt_n_o[3:1] == 3'h7;
	endproperty
	a_ext_idle: assert property (p_ext_idle) else $error("grant level");
	property p_strap;
		ok |-> int_arb_mode == arbiter_enable_strap;
	endproperty
	a_strap: assert property (p_strap) else $error("mode wrong");
	property p_own_gnt;
		ok && !int_arb_mode |=> own_gnt == !$past(pins_i.gnt0_n_i);
	endproperty
	a_own_gnt: assert property (p_own_gnt) else $error("own grant");
	property p_req0;
		ok && !int_arb_mode |=> !pins_o.req0_oe_n
			&& pins_o.req0_n_o == !$past(own_req);
	endproperty
	a_req0: assert property (p_req0) else $error("request out");
	property p_req_in;
		ok && int_arb_mode |-> pins_o.req0_oe_n;
	endproperty
	a_req_in: assert property (p_req_in) else $error("request dir");
	property p_park;
		(ok && int_arb_mode && test_spare2 && !own_req
			&& pins_i.req_n_i == 4'hF) [*7] |-> pins_o.gnt_n_o == 4'h7;
	endproperty
	a_park: assert property (p_park) else $error("park wrong");
	property p_irdy;
		(ok && own_gnt && own_active && own_ready) [*3]
			|=> !pins_o.irdy_oe_n && !pins_o.irdy_n_o;
	endproperty
	a_irdy: assert property (p_irdy) else $error("ready wrong");
	property p_lock;
		ok && own_lock && own_gnt && own_active
			|=> !pins_o.lock_oe_n && !pins_o.lock_n_o;
	endproperty
	a_lock: assert property (p_lock) else $error("lock wrong");
	property p_unlock;
		ok && $fell(own_lock) |=> pins_o.lock_oe_n;
	endproperty
	a_unlock: assert property (p_unlock) else $error("lock held");
	c_ext: cover property (ok && !pins_o.gnt_n_o[3]);
	c_own: cover property (ok && !int_arb_mode && own_gnt);
	c_park: cover property (ok && pins_o.gnt_n_o == 4'h7);
endmodule
`default_nettype wire

// >>> verif/pgr_far_model.sv
// Far side: PCI masters, external arbiter, pull-ups.
// Assumes ext_mode matches the strap given to the block.
`timescale 1ns/1ps
`default_nettype none
module pgr_far_model
	import pgr_pkg::*;
(
	input wire logic                   core_clk,
	input wire logic                   ext_mode,
	input wire logic [3:0]             want,
	input wire logic                   ext_busy,
	input wire logic                   ext_lock,
	input wire pgr_pkg::pgr_pins_out_t pins_o,
	output var pgr_pkg::pgr_pins_in_t  pins_i
);
	logic       gnt0_q;
	logic [3:0] req_w;
	// External arbiter grants one cycle after request
	always_ff @(posedge core_clk) begin
		gnt0_q <= ext_mode ? req_w[0] : 1'b1;
	end
	// Request 3..1 pulled high in external mode
	assign req_w = ext_mode ? {3'h7, pins_o.req0_oe_n | pins_o.req0_n_o}
		: ~want;
	// Released lines float high; another master may hold FRAME or LOCK
	assign pins_i = '{req_w, gnt0_q, ~ext_busy,
		pins_o.irdy_oe_n | pins_o.irdy_n_o,
		(pins_o.lock_oe_n | pins_o.lock_n_o) & ~ext_lock};
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for pgr_top.
// Assumes pgr_pkg, pgr_top, checker and far model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pgr_pkg::*;
	logic          core_clk = 1'b0;
	logic          nrst = 1'b0;
	logic          strap = 1'b1;
	logic          spare2 = 1'b0;
	logic          own_req = 1'b0;
	logic          own_active = 1'b0;
	logic          own_ready = 1'b0;
	logic          own_lock = 1'b0;
	logic [3:0]    want = 4'h0;
	logic          ext_busy = 1'b0;
	logic          ext_lock = 1'b0;
	pgr_pins_in_t  pins_i;
	pgr_pins_out_t pins_o;
	logic          own_gnt;
	logic          int_arb_mode;
	logic          lock_busy;
	logic [3:0]    ext_gnt_state;
	int            mismatches = 0;
	int            check_count = 0;
	always #25 core_clk = ~core_clk;
	pgr_top pgr_top_inst (.core_clk(core_clk), .nrst(nrst),
		.arbiter_enable_strap(strap), .test_spare2(spare2),
		.pins_i(pins_i), .pins_o(pins_o), .own_req(own_req),
		.own_active(own_active), .own_ready(own_ready),
		.own_lock(own_lock), .own_gnt(own_gnt),
		.int_arb_mode(int_arb_mode), .lock_busy(lock_busy),
		.ext_gnt_state(ext_gnt_state));
	pgr_far_model pgr_far_model_inst (.core_clk(core_clk),
		.ext_mode(~strap), .want(want), .ext_busy(ext_busy),
		.ext_lock(ext_lock), .pins_o(pins_o), .pins_i(pins_i));
	task automatic end_sim;
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %0h vs %0h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wt(input logic sel, input logic [3:0] exp);
		for (int i = 0; i < 30; i++) begin
			if ((sel ? {3'h0, own_gnt} : ext_gnt_state) === exp)
				return;
			tick(1);
		end
		mismatches++;
		end_sim();
	endtask
	task automatic do_reset(input logic s);
		nrst = 1'b0;
		strap = s;
		tick(5);
		nrst = 1'b1;
		tick(8);
	endtask
	task automatic t_internal;
		do_reset(1'b1);
		chk(int_arb_mode, 1'b1);
		chk(pins_o.req0_oe_n, 1'b1);
		for (int i = 0; i < 4; i++) begin
			want = 4'h1 << i;
			wt(1'b0, 4'h1 << i);
			chk({pins_o.gnt_oe_n, pins_o.gnt_n_o}, {4'h0, ~(4'h1 << i)});
			chk(own_gnt, 1'b0);
			want = 4'h0;
			wt(1'b1, 4'h1);
		end
	endtask
	task automatic t_park;
		spare2 = 1'b1;
		do_reset(1'b1);
		chk(pins_o.gnt_n_o, 4'h7);
		chk(own_gnt, 1'b0);
		tick(8);
		want = 4'h4;
		wt(1'b0, 4'h4);
		want = 4'h0;
		wt(1'b0, 4'h8);
	endtask
	task automatic t_busy;
		ext_busy = 1'b1;
		tick(2);
		want = 4'h4;
		tick(6);
		chk(ext_gnt_state, 4'h0);
		ext_busy = 1'b0;
		wt(1'b0, 4'h4);
		ext_lock = 1'b1;
		tick(2);
		chk(lock_busy, 1'b1);
		ext_lock = 1'b0;
		want = 4'h0;
		tick(2);
		chk(lock_busy, 1'b0);
	endtask
	task automatic t_ext;
		spare2 = 1'b0;
		want = 4'hE;
		do_reset(1'b0);
		chk(int_arb_mode, 1'b0);
		chk({pins_o.gnt_oe_n, pins_o.gnt_n_o}, 8'h1F);
		chk(own_gnt, 1'b0);
		own_req = 1'b1;
		tick(1);
		chk({pins_o.req0_oe_n, pins_o.req0_n_o}, 2'h0);
		wt(1'b1, 4'h1);
		own_active = 1'b1;
		own_ready = 1'b1;
		own_lock = 1'b1;
		tick(4);
		chk({pins_o.irdy_oe_n, pins_o.irdy_n_o, pins_o.lock_oe_n}, 3'h0);
		chk(lock_busy, 1'b0);
		own_lock = 1'b0;
		tick(2);
		chk(pins_o.lock_oe_n, 1'b1);
		own_ready = 1'b0;
		tick(2);
		chk({pins_o.irdy_oe_n, pins_o.irdy_n_o}, 2'h1);
		own_req = 1'b0;
		tick(3);
		chk(own_gnt, 1'b0);
	endtask
	initial begin
		t_internal();
		t_busy();
		t_park();
		t_ext();
		end_sim();
	end
endmodule
bind pgr_top pgr_sva pgr_sva_inst (
	.core_clk             (core_clk),
	.nrst                 (nrst),
	.arbiter_enable_strap (arbiter_enable_strap),
	.test_spare2          (test_spare2),
	.pins_i               (pins_i),
	.pins_o               (pins_o),
	.own_req              (own_req),
	.own_active           (own_active),
	.own_ready            (own_ready),
	.own_lock             (own_lock),
	.own_gnt              (own_gnt),
	.int_arb_mode         (int_arb_mode),
	.ext_gnt_state        (ext_gnt_state)
);
`default_nettype wire
